// file: hdl/nvmpw_core_end.sv
`timescale 1ns/1ps
// Purpose: core-side end; turns user commands into one-cycle link strobes
// Assumes: user holds a command for one cycle when cmd_ready is high
// Notes: one link strobe per command; cmd_ready only drops while reset is held
module nvmpw_core_end (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // link
  nvmpw_if.core link,
  // user command
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  // user answer
  output logic cmd_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic busy
);
  typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_CTRL, CMD_STEP} nvmpw_cmd_type;
  logic xd_rd_q, xd_rd_d, xd_wr_q, xd_wr_d, ctrl_wr_q, ctrl_wr_d, step_q, step_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d, cdata_q, cdata_d, rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d, busy_q, busy_d, ready_q, ready_d;

  //////////////////////////////////////////////////////////////////////////////
  // software keeps the page bits fixed and interrupts off; not checked here
  // see (RULE_11) see (RULE_12) see (RULE_13) see (RULE_14)
  always_comb begin
    xd_rd_d = 1'b0;
    xd_wr_d = 1'b0;
    ctrl_wr_d = 1'b0;
    step_d = 1'b0;
    addr_d = addr_q;
    wdata_d = wdata_q;
    cdata_d = cdata_q;
    if (cmd_valid) begin
      unique case (nvmpw_cmd_type'(cmd_kind))
        CMD_READ: begin
          xd_rd_d = 1'b1;
          addr_d = cmd_addr;
        end
        CMD_WRITE: begin
          xd_wr_d = 1'b1;
          addr_d = cmd_addr;
          wdata_d = cmd_data;
        end
        CMD_CTRL: begin
          ctrl_wr_d = 1'b1; // see (RULE_15)
          cdata_d = cmd_data;
        end
        CMD_STEP: begin
          step_d = 1'b1;
        end
      endcase
    end
    rd_valid_d = link.xd_rvalid;
    rd_data_d = link.xd_rvalid ? link.xd_rdata : rd_data_q;
    busy_d = link.ctrl_rdata[nvmpw_pkg::CTRL_BUSY_BIT];
    // the core end never stalls, so ready is only low under reset
    ready_d = 1'b1;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      xd_rd_q <= 1'b0;
      xd_wr_q <= 1'b0;
      ctrl_wr_q <= 1'b0;
      step_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      cdata_q <= 8'h00;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
      busy_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      xd_rd_q <= xd_rd_d;
      xd_wr_q <= xd_wr_d;
      ctrl_wr_q <= ctrl_wr_d;
      step_q <= step_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      cdata_q <= cdata_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      busy_q <= busy_d;
      ready_q <= ready_d;
    end
  end

  assign link.xd_rd = xd_rd_q;
  assign link.xd_wr = xd_wr_q;
  assign link.ctrl_wr = ctrl_wr_q;
  assign link.instr_step = step_q;
  assign link.xd_addr = addr_q;
  assign link.xd_wdata = wdata_q;
  assign link.ctrl_wdata = cdata_q;
  assign cmd_ready = ready_q;
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign busy = busy_q;
endmodule

// file: hdl/nvmpw_if.sv
`timescale 1ns/1ps
// Purpose: join of the core-side requester and the nonvolatile access end
// Assumes: single clock, requests are one-cycle strobes
// Notes: ctrl_wr is a write of the control register, xd_* are external data moves
interface nvmpw_if;
  logic xd_rd;
  logic xd_wr;
  logic [15:0] xd_addr;
  logic [7:0] xd_wdata;
  logic ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic instr_step;
  logic [7:0] xd_rdata;
  logic xd_rvalid;
  logic [7:0] ctrl_rdata;
  modport core (
    output xd_rd, xd_wr, xd_addr, xd_wdata, ctrl_wr, ctrl_wdata, instr_step,
    input xd_rdata, xd_rvalid, ctrl_rdata
  );
  modport nvm (
    input xd_rd, xd_wr, xd_addr, xd_wdata, ctrl_wr, ctrl_wdata, instr_step,
    output xd_rdata, xd_rvalid, ctrl_rdata
  );
endinterface

// file: hdl/nvmpw_nvm_end.sv
`timescale 1ns/1ps
// Purpose: nonvolatile data array with column latches and row programming
// Assumes: one link request per cycle; instr_step marks any other executed instruction
// Notes: the array is modelled as registers; contents survive only while powered
// Overview of operation
// (RULE_01) 2-Kbyte array at 0000h-07FFh when mapped
// (RULE_02) array selected only by control map bit
// (RULE_03) mapped read returns stored byte
// (RULE_04) write: latch bytes, then program one row
// (RULE_05) load one to 128 bytes before programming
// (RULE_06) program only bytes loaded since last program
// (RULE_07) tag bit set on each latch write
// (RULE_08) clear all tags after row programmed
// (RULE_09) mapped external write captures byte into latch
// (RULE_10) upper 4 bits row, lower 7 byte
// (RULE_11) software keeps page bits fixed between programs
// (RULE_12) software disables interrupts while loading latches
// (RULE_13) software sets map bit before latch writes
// (RULE_14) software loads pointer and accumulator before write
// (RULE_15) program launches on 50h then A0h writes
// (RULE_16) busy flag during programming, reads blocked
// (RULE_17) intervening instruction aborts the launch sequence
// (RULE_18) unmapped accesses go to expanded ram
module nvmpw_nvm_end #(
  parameter int ARRAY_BYTES = 2048,
  parameter int PAGE_BYTES = 128,
  parameter int PROG_CYCLES = nvmpw_pkg::PROG_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // link
  nvmpw_if.nvm link
);
  typedef enum logic [1:0] {NV_IDLE, NV_ARMED, NV_PROG} nvmpw_state_type;

  function automatic logic in_array(input logic [15:0] a);
    in_array = (a <= nvmpw_pkg::ARRAY_LAST); // see (RULE_01)
  endfunction

  // launch codes live in the upper nibble; the lower bits are don't-care
  function automatic logic is_code(input logic [7:0] w, input logic [3:0] c);
    is_code = (w[7:nvmpw_pkg::CTRL_CODE_LSB] == c);
  endfunction

  logic [7:0] array_q [ARRAY_BYTES];
  logic [7:0] on_chip_expanded_ram_q [ARRAY_BYTES];
  logic [7:0] latch_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] tag_q, tag_d;
  logic [nvmpw_pkg::PAGE_AW-1:0] row_q, row_d;
  logic map_q, map_d;
  logic [3:0] page_hi_q, page_hi_d;
  logic [7:0] ctrl_q, ctrl_d;
  nvmpw_state_type state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic hit, lwr, prog_done, on_chip_expanded_ram_sel;
  logic [nvmpw_pkg::BYTE_AW-1:0] col;
  logic [nvmpw_pkg::PAGE_AW-1:0] pg;
  logic [nvmpw_pkg::ARRAY_AW-1:0] aidx;

  //////////////////////////////////////////////////////////////////////////////
  // decode
  assign aidx = link.xd_addr[nvmpw_pkg::ARRAY_AW-1:0];
  assign col = aidx[nvmpw_pkg::BYTE_AW-1:0]; // see (RULE_10)
  assign pg = aidx[nvmpw_pkg::ARRAY_AW-1:nvmpw_pkg::BYTE_AW];
  assign hit = map_q && in_array(link.xd_addr); // see (RULE_02)
  assign lwr = link.xd_wr && hit && (state_q != NV_PROG); // see (RULE_09)
  // unmapped accesses in the array range fall through to the expanded ram
  assign on_chip_expanded_ram_sel = !map_q && in_array(link.xd_addr); // see (RULE_18)
  // counter runs from PROG_CYCLES down to 1, so busy lasts exactly PROG_CYCLES cycles
  assign prog_done = (state_q == NV_PROG) && (cnt_q == 16'h0001);

  //////////////////////////////////////////////////////////////////////////////
  // control register, launch sequence and programming timer
  always_comb begin
    map_d = map_q;
    page_hi_d = page_hi_q;
    state_d = state_q;
    cnt_d = cnt_q;
    if (link.ctrl_wr) begin
      map_d = link.ctrl_wdata[nvmpw_pkg::CTRL_MAP_BIT];
      page_hi_d = link.ctrl_wdata[7:nvmpw_pkg::CTRL_CODE_LSB];
    end
    unique case (state_q)
      NV_IDLE: begin
        if (link.ctrl_wr && is_code(link.ctrl_wdata, nvmpw_pkg::LAUNCH_FIRST)) begin
          state_d = NV_ARMED;
        end
      end
      NV_ARMED: begin
        // idle link cycles and a repeated first code keep the pair armed; any other executed instruction breaks it
        if (link.ctrl_wr && is_code(link.ctrl_wdata, nvmpw_pkg::LAUNCH_SECOND)) begin
          state_d = NV_PROG; // see (RULE_15)
          cnt_d = 16'(PROG_CYCLES);
        end else if (link.ctrl_wr && is_code(link.ctrl_wdata, nvmpw_pkg::LAUNCH_FIRST)) begin
          state_d = NV_ARMED;
        end else if (link.ctrl_wr || link.xd_rd || link.xd_wr || link.instr_step) begin
          state_d = NV_IDLE; // see (RULE_17)
        end
      end
      NV_PROG: begin
        cnt_d = cnt_q - 16'h0001;
        if (prog_done) begin
          state_d = NV_IDLE; // see (RULE_16)
        end
      end
      // the fourth code of the state register is unused; fall back to idle
      default: begin
        state_d = NV_IDLE;
      end
    endcase
    // readback is registered so the core end samples a flop, not decode logic
    ctrl_d = nvmpw_pkg::CTRL_RESET;
    ctrl_d[7:nvmpw_pkg::CTRL_CODE_LSB] = page_hi_d;
    ctrl_d[nvmpw_pkg::CTRL_MAP_BIT] = map_d; // see (RULE_02)
    ctrl_d[nvmpw_pkg::CTRL_BUSY_BIT] = (state_d == NV_PROG); // see (RULE_16)
  end

  // tags and row: first loaded page address is kept, later ones discarded
  always_comb begin
    tag_d = tag_q;
    row_d = row_q;
    if (lwr) begin
      if (tag_q == '0) begin
        row_d = pg;
      end
      tag_d[col] = 1'b1; // see (RULE_07) see (RULE_05)
    end
    if (prog_done) begin
      tag_d = '0; // see (RULE_08)
    end
  end

  // read path; busy blocks array reads and answers zero
  always_comb begin
    rvalid_d = link.xd_rd;
    rdata_d = 8'h00;
    if (link.xd_rd) begin
      if (hit) begin
        if (state_q != NV_PROG) begin
          rdata_d = array_q[aidx]; // see (RULE_03) see (RULE_16)
        end
      end else if (on_chip_expanded_ram_sel) begin
        rdata_d = on_chip_expanded_ram_q[aidx]; // see (RULE_18)
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers, one process per group of state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      map_q <= 1'b0;
      page_hi_q <= 4'h0;
      state_q <= NV_IDLE;
      cnt_q <= 16'h0000;
      ctrl_q <= nvmpw_pkg::CTRL_RESET;
    end else begin
      map_q <= map_d;
      page_hi_q <= page_hi_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      ctrl_q <= ctrl_d;
    end
  end

  // tags clear on reset, so a page left half loaded is dropped
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tag_q <= '0;
      row_q <= '0;
    end else begin
      tag_q <= tag_d;
      row_q <= row_d;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // memories carry no reset: nonvolatile contents must not be cleared
  always_ff @(posedge clock) begin
    if (lwr) begin
      latch_q[col] <= link.xd_wdata; // see (RULE_04)
    end
    if (link.xd_wr && on_chip_expanded_ram_sel) begin
      on_chip_expanded_ram_q[aidx] <= link.xd_wdata; // see (RULE_18)
    end
    if (prog_done) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (tag_q[i]) begin
          array_q[{row_q, 7'(i)}] <= latch_q[i]; // see (RULE_06) see (RULE_04)
        end
      end
    end
  end

  assign link.xd_rdata = rdata_q;
  assign link.xd_rvalid = rvalid_q;
  assign link.ctrl_rdata = ctrl_q;
endmodule

// file: hdl/nvmpw_pkg.sv
// Purpose: shared constants for the nonvolatile page-write access block
// Assumes: one 10 MHz clock, asynchronous active-low reset
// Notes: control register layout follows the map/busy/page field positions
package nvmpw_pkg;
  localparam int ADDR_W = 16;
  localparam int ARRAY_AW = 11;
  localparam int PAGE_AW = 4;
  localparam int BYTE_AW = 7;
  localparam logic [15:0] ARRAY_LAST = 16'h07ff;
  localparam int CTRL_MAP_BIT = 1;
  localparam int CTRL_BUSY_BIT = 0;
  localparam int CTRL_CODE_LSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] LAUNCH_FIRST = 4'h5;
  localparam logic [3:0] LAUNCH_SECOND = 4'ha;
  // programming time per row, microseconds, and its cycle count at 10 MHz
  localparam int PROG_TIME_US = 10;
  localparam int CLOCK_MHZ = 10;
  localparam int PROG_CYCLES = PROG_TIME_US * CLOCK_MHZ;
  localparam logic [7:0] ON_CHIP_EXPANDED_RAM_RESET = 8'h00;
endpackage

// file: sim/eeprom_page_write_access_tb.sv
// Purpose: end-to-end bench for the page-write access pair
// Assumes: 10 MHz clock, reset held 3 cycles
// Notes: programming shortened to 12 cycles so busy reads fit inside
`timescale 1ns/1ps
module eeprom_page_write_access_tb;
  typedef struct {logic [15:0] a; logic [7:0] d;} nvmpw_row_type;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_kind = 2'h0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, rd_valid, busy;
  logic [7:0] rd_data, g;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  // one row per programming session; same row three times shows untouched bytes survive
  nvmpw_row_type rows [4] = '{'{16'h0100, 8'ha5}, '{16'h017f, 8'h3c},
    '{16'h0101, 8'h5a}, '{16'h07ff, 8'hc3}};
  nvmpw_if link ();
  nvmpw_core_end nvmpw_core_end_inst (.clock(clock), .resetn(resetn), .link(link),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy));
  nvmpw_nvm_end #(.PROG_CYCLES(12)) nvmpw_nvm_end_inst (.clock(clock), .resetn(resetn),
    .link(link));
  nvmpw_checker #(.PROG_CYCLES(12)) nvmpw_checker_inst (.clock(clock), .resetn(resetn),
    .xd_rd(link.xd_rd), .xd_wr(link.xd_wr), .xd_addr(link.xd_addr), .ctrl_wr(link.ctrl_wr),
    .ctrl_wdata(link.ctrl_wdata), .instr_step(link.instr_step), .xd_rdata(link.xd_rdata),
    .xd_rvalid(link.xd_rvalid), .ctrl_rdata(link.ctrl_rdata));
  ////////////////////////////////////////
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      end_of_test();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
    compares++;
    if (v !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic cmd(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    cmd(2'h0, a, 8'h00);
    for (int i = 0; i < 8 && rd_valid !== 1'b1; i++)
      @(negedge clock);
    v = rd_data;
  endtask
  task automatic launch();
    cmd(2'h2, 16'h0000, 8'h50);
    cmd(2'h2, 16'h0000, 8'ha0);
    // busy reaches the core end's register two edges after the second code
    repeat (3) @(negedge clock);
  endtask
  task automatic idle();
    for (int i = 0; i < 40 && busy !== 1'b0; i++)
      @(negedge clock);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    chk("busy", 8'h00, {7'h00, busy});
    chk("ctrl", nvmpw_pkg::CTRL_RESET, link.ctrl_rdata);
    $display("test reset done");
    foreach (rows[i]) begin
      cmd(2'h2, 16'h0000, 8'h02);
      cmd(2'h1, rows[i].a, rows[i].d);
      launch();
      chk("busy", 8'h01, {7'h00, busy});
      idle();
      chk("busy", 8'h00, {7'h00, busy});
    end
    cmd(2'h2, 16'h0000, 8'h02);
    foreach (rows[i]) begin
      rd(rows[i].a, g);
      chk("array", rows[i].d, g);
    end
    $display("test rows done");
    cmd(2'h1, 16'h0300, 8'h44);
    cmd(2'h2, 16'h0000, 8'h50);
    cmd(2'h3, 16'h0000, 8'h00);
    cmd(2'h2, 16'h0000, 8'ha0);
    repeat (3) @(negedge clock);
    chk("busy", 8'h00, {7'h00, busy});
    launch();
    cmd(2'h2, 16'h0000, 8'h02);
    rd(16'h0300, g);
    chk("busy read", 8'h00, g);
    idle();
    rd(16'h0300, g);
    chk("array", 8'h44, g);
    rd(16'h0800, g);
    chk("high", 8'h00, g);
    $display("test launch done");
    cmd(2'h2, 16'h0000, 8'h00);
    cmd(2'h1, 16'h0100, 8'h99);
    rd(16'h0100, g);
    chk("ram", 8'h99, g);
    cmd(2'h2, 16'h0000, 8'h02);
    rd(16'h0100, g);
    chk("array", 8'ha5, g);
    $display("test map done");
    // reset in mid-run: control and ready drop, expanded ram keeps its data
    @(posedge clock);
    resetn <= 1'b0;
    @(negedge clock);
    chk("ctrl", nvmpw_pkg::CTRL_RESET, link.ctrl_rdata);
    chk("ready", 8'h00, {7'h00, cmd_ready});
    @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(negedge clock);
    chk("ready", 8'h01, {7'h00, cmd_ready});
    rd(16'h0100, g);
    chk("ram", 8'h99, g);
    $display("test reset again done");
    end_of_test();
  end
endmodule

// file: sim/nvmpw_checker.sv
// Purpose: link checks between the core end and the array end
// Assumes: one clock, resetn low active
// Notes: busy is ctrl_rdata bit 0, map is bit 1
`timescale 1ns/1ps
module nvmpw_checker #(
  parameter int PROG_CYCLES = nvmpw_pkg::PROG_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // link signals
  input wire logic xd_rd,
  input wire logic xd_wr,
  input wire logic [15:0] xd_addr,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic instr_step,
  input wire logic [7:0] xd_rdata,
  input wire logic xd_rvalid,
  input wire logic [7:0] ctrl_rdata
);
  logic busy;
  logic armed_q, armed_d, go_q, go_d;
  logic [7:0] bcnt_q, bcnt_d;
  assign busy = ctrl_rdata[0];
  ////////////////////////////////////////
  // idle cycles keep the launch armed; only a strobe breaks it
  // a first code written while busy is ignored by the array end
  always_comb begin
    armed_d = armed_q;
    if (xd_rd || xd_wr || instr_step || ctrl_wr)
      armed_d = 1'b0;
    if (ctrl_wr && ctrl_wdata[7:4] == nvmpw_pkg::LAUNCH_FIRST && !busy)
      armed_d = 1'b1;
    go_d = ctrl_wr && ctrl_wdata[7:4] == nvmpw_pkg::LAUNCH_SECOND && armed_q;
    bcnt_d = busy ? bcnt_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      armed_q <= 1'b0;
      go_q <= 1'b0;
      bcnt_q <= 8'h00;
    end else begin
      armed_q <= armed_d;
      go_q <= go_d;
      bcnt_q <= bcnt_d;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  AST_READ_ANSWER: assert property (xd_rd |=> xd_rvalid)
    else $error("read strobe got no answer");
  AST_LAUNCH: assert property (go_q |-> busy)
    else $error("launch pair did not set busy");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> go_q)
    else $error("busy rose without a clean launch pair");
  AST_BUSY_MIN: assert property ($fell(busy) |-> bcnt_q >= PROG_CYCLES)
    else $error("busy ended early");
  AST_BUSY_MAX: assert property (busy |-> bcnt_q <= PROG_CYCLES)
    else $error("busy lasted too long");
  AST_BUSY_READ: assert property (xd_rd && busy && ctrl_rdata[1] &&
    xd_addr <= nvmpw_pkg::ARRAY_LAST |=> xd_rdata == 8'h00)
    else $error("array read while busy not blocked");
  AST_HIGH_ADDR: assert property (xd_rd && ctrl_rdata[1] &&
    xd_addr > nvmpw_pkg::ARRAY_LAST |=> xd_rdata == 8'h00)
    else $error("read above array gave data");
  AST_MAP: assert property (ctrl_wr && ctrl_wdata[1] |=> ctrl_rdata[1])
    else $error("map bit not set by control write");
endmodule
